//--- shared/bbx_pkg.sv
// shared constants and types of the bit and branch executor
package bbx_pkg;
  // opcodes with a fixed code
  localparam logic [7:0] OP_C_AND = 8'h8b;
  localparam logic [7:0] OP_XOR1 = 8'hab;
  localparam logic [7:0] OP_C_OR = 8'h6b;
  localparam logic [7:0] OP_C_LOAD = 8'hcb;
  localparam logic [7:0] OP_M_INV = 8'h4b;
  localparam logic [7:0] OP_C_STORE = 8'heb;
  localparam logic [7:0] OP_BIT_DP = 8'h0c;
  localparam logic [7:0] OP_BIT_ABS = 8'h1c;
  localparam logic [7:0] OP_TCLR = 8'h5c;
  localparam logic [7:0] OP_TSET = 8'h3c;
  localparam logic [7:0] OP_ACLR = 8'h2b;
  localparam logic [7:0] OP_ASET = 8'h0b;
  localparam logic [7:0] OP_C_CLEAR = 8'h20;
  localparam logic [7:0] OP_C_FORCE = 8'ha0;
  localparam logic [7:0] OP_G_CLEAR = 8'h40;
  localparam logic [7:0] OP_G_FORCE = 8'hc0;
  localparam logic [7:0] OP_V_CLEAR = 8'h80;
  localparam logic [7:0] OP_BR_C0 = 8'h50;
  localparam logic [7:0] OP_BR_C1 = 8'hd0;
  localparam logic [7:0] OP_BR_Z1 = 8'hf0;
  localparam logic [7:0] OP_BR_Z0 = 8'h70;
  localparam logic [7:0] OP_BR_N1 = 8'h90;
  localparam logic [7:0] OP_BR_N0 = 8'h10;
  // low-nibble families; opcode bits 7:5 carry the bit number
  localparam logic [3:0] NIB_MBIT = 4'h1;
  localparam logic [3:0] NIB_BB_A = 4'h2;
  localparam logic [3:0] NIB_BB_DP = 4'h3;
  localparam int OPB_CLR = 4;
  localparam int OPB_BIT = 5;
  // memory-bit operand word: address, invert flag, bit number
  localparam int MB_ADDR_MSB = 11;
  localparam int MB_INV = 12;
  localparam int MB_BIT = 13;
  // byte counts and cycle counts
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;
  localparam logic [3:0] CYC_C_AND = 4'h4;
  localparam logic [3:0] CYC_XOR1 = 4'h5;
  localparam logic [3:0] CYC_C_OR = 4'h5;
  localparam logic [3:0] CYC_C_LOAD = 4'h4;
  localparam logic [3:0] CYC_M_INV = 4'h5;
  localparam logic [3:0] CYC_C_STORE = 4'h6;
  localparam logic [3:0] CYC_BIT_DP = 4'h4;
  localparam logic [3:0] CYC_BIT_ABS = 4'h5;
  localparam logic [3:0] CYC_TST = 4'h6;
  localparam logic [3:0] CYC_MBIT = 4'h4;
  localparam logic [3:0] CYC_ABIT = 4'h2;
  localparam logic [3:0] CYC_FLAG = 4'h2;
  localparam logic [3:0] CYC_BR = 4'h2;
  localparam logic [3:0] CYC_BB_A = 4'h4;
  localparam logic [3:0] CYC_BB_DP = 4'h5;
  localparam logic [3:0] CYC_TAKEN = 4'h2;
  // register byte offsets and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0c;
  localparam logic [7:0] REG_PSW = 8'h10;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLR_ILL = 1;
  // status word, flag layout n v g b h i z c
  typedef struct packed {
    logic n, v, g, b, h, i, z, c;
  } bbx_psw_s;
  typedef struct packed {
    logic legal;
    logic [1:0] len;
    logic [3:0] cyc;
  } bbx_dec_s;
endpackage

//--- rtl/bbx_exec.sv
// bit manipulation and conditional branch executor with its register slave
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - carry ands memory bit, optionally inverted
// - carry xors memory bit, five cycles
// - carry ors memory bit, five cycles
// - carry loads memory bit or its complement
// - bit test sets zero, negative, overflow
// - direct page bit cleared or set
// - accumulator bit cleared or set
// - single byte flag set and clear
// - memory bit inverted in place
// - carry stored into memory bit
// - test then clear memory bits selected by the accumulator
// - test then set memory bits selected by the accumulator
// - branch when tested bit is zero
// - branch when tested bit is one
// - branch on carry clear or set
// - branch on zero set or clear
module bbx_exec
  import bbx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // program memory, combinational read
  output logic [15:0] pm_addr,
  input wire logic [7:0] pm_rdata,
  // data memory, combinational read, clocked write
  output logic [15:0] dm_addr,
  input wire logic [7:0] dm_rdata,
  output logic dm_we,
  output logic [7:0] dm_wdata
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  // byte count and base cycle count of each opcode
  function automatic bbx_dec_s decode(input logic [7:0] o);
    bbx_dec_s d;
    d = '{1'b1, LEN2, CYC_BR};
    case (o)
      OP_C_AND: d = '{1'b1, LEN3, CYC_C_AND};
      OP_XOR1: d = '{1'b1, LEN3, CYC_XOR1};
      OP_C_OR: d = '{1'b1, LEN3, CYC_C_OR};
      OP_C_LOAD: d = '{1'b1, LEN3, CYC_C_LOAD};
      OP_M_INV: d = '{1'b1, LEN3, CYC_M_INV};
      OP_C_STORE: d = '{1'b1, LEN3, CYC_C_STORE};
      OP_BIT_DP: d = '{1'b1, LEN2, CYC_BIT_DP};
      OP_BIT_ABS: d = '{1'b1, LEN3, CYC_BIT_ABS};
      OP_TCLR, OP_TSET: d = '{1'b1, LEN3, CYC_TST};
      OP_ACLR, OP_ASET: d = '{1'b1, LEN2, CYC_ABIT};
      OP_C_CLEAR, OP_C_FORCE, OP_G_CLEAR, OP_G_FORCE, OP_V_CLEAR:
        d = '{1'b1, LEN1, CYC_FLAG};
      OP_BR_C0, OP_BR_C1, OP_BR_Z1, OP_BR_Z0, OP_BR_N1, OP_BR_N0:
        d = '{1'b1, LEN2, CYC_BR};
      default:
      begin
        // families carry the bit number in the opcode
        if (o[3:0] == NIB_MBIT)
          d = '{1'b1, LEN2, CYC_MBIT};
        else if (o[3:0] == NIB_BB_A)
          d = '{1'b1, LEN2, CYC_BB_A};
        else if (o[3:0] == NIB_BB_DP)
          d = '{1'b1, LEN3, CYC_BB_DP};
        else
          d = '{1'b0, LEN1, CYC_FLAG};
      end
    endcase
    return d;
  endfunction

  // ----------------------------------------
  // architectural and sequencing state
  // ----------------------------------------
  logic [15:0] pc; // address of the next opcode
  logic [7:0] acc; // accumulator
  bbx_psw_s psw; // flags
  logic [7:0] op_q; // opcode latched in cycle 0
  logic [7:0] b1_q; // first operand byte
  logic [7:0] b2_q; // second operand byte
  logic [3:0] cyc; // cycle within the instruction, 0 when idle
  logic run; // software lets instructions start
  logic illegal; // sticky: an unknown opcode halted the core
  bbx_psw_s next_psw;
  logic [7:0] next_acc;

  // ----------------------------------------
  // operand selection
  // ----------------------------------------
  wire active = (cyc != 4'h0);
  wire idle = !active && !run;
  wire bbx_dec_s dec = decode(op_q);
  wire [3:0] nib = op_q[3:0];
  // operand bytes are taken straight off the bus in their own fetch cycle
  wire [7:0] byte1 = (cyc == 4'h1) ? pm_rdata : b1_q;
  wire [7:0] byte2 = (cyc == 4'h2) ? pm_rdata : b2_q;
  wire [15:0] word = {byte2, byte1};
  wire is_mbit = (op_q == OP_C_AND) || (op_q == OP_XOR1) || (op_q == OP_C_OR) ||
                 (op_q == OP_C_LOAD) || (op_q == OP_M_INV) || (op_q == OP_C_STORE);
  wire is_abs = (op_q == OP_BIT_ABS) || (op_q == OP_TCLR) || (op_q == OP_TSET);
  wire [2:0] bsel = is_mbit ? word[15:MB_BIT] : op_q[7:OPB_BIT];
  wire inv = is_mbit && word[MB_INV];
  wire mbit = dm_rdata[bsel];
  // memory bit after the optional inversion
  wire mbe = mbit ^ inv;
  // accumulator bit instructions take the bit number from the operand
  wire [2:0] abit = byte1[2:0];
  wire [7:0] amask = 8'h01 << abit;
  wire [7:0] diff = acc - dm_rdata;

  // ----------------------------------------
  // branch decision
  // ----------------------------------------
  wire is_flag_br = (op_q == OP_BR_C0) || (op_q == OP_BR_C1) || (op_q == OP_BR_Z1) ||
                    (op_q == OP_BR_Z0) || (op_q == OP_BR_N1) || (op_q == OP_BR_N0);
  wire is_bb = (nib == NIB_BB_A) || (nib == NIB_BB_DP);
  // bit set test
  // a bit opcode with bit 4 set branches on zero, clear branches on one
  wire bb_take = ((nib == NIB_BB_A) ? acc[bsel] : mbit) ^ op_q[OPB_CLR];
  wire c_take = (op_q == OP_BR_C1) ? psw.c : !psw.c;
  wire z_take = (op_q == OP_BR_Z1) ? psw.z : !psw.z;
  wire n_take = (op_q == OP_BR_N1) ? psw.n : !psw.n;
  wire fl_take = ((op_q == OP_BR_C0) || (op_q == OP_BR_C1)) ? c_take :
                 ((op_q == OP_BR_Z1) || (op_q == OP_BR_Z0)) ? z_take : n_take;
  wire take = (is_bb && bb_take) || (is_flag_br && fl_take);
  wire [7:0] rel = (nib == NIB_BB_DP) ? byte2 : byte1;
  wire [15:0] rel_sx = {{8{rel[7]}}, rel};
  // a taken branch spends two more cycles
  wire [3:0] total = dec.cyc + (take ? CYC_TAKEN : 4'h0);
  wire fin = active && dec.legal && (cyc == total - 4'h1);
  wire ill_hit = active && (cyc == 4'h1) && !dec.legal;
  wire [15:0] pc_seq = pc + {14'h0000, dec.len};
  wire [15:0] next_pc = take ? pc_seq + rel_sx : pc_seq;

  // ----------------------------------------
  // memory ports
  // ----------------------------------------
  // program bytes are read at pc plus the cycle number
  assign pm_addr = pc + {12'h000, cyc};
  // bit-operand words hold a 12 bit address, dp forms stay in page zero
  assign dm_addr = is_mbit ? {4'h0, word[MB_ADDR_MSB:0]} :
                   is_abs ? word : {8'h00, byte1};
  wire [7:0] bmask = 8'h01 << bsel;
  // value written into the selected bit
  wire wbit = (op_q == OP_C_STORE) ? psw.c :
              (op_q == OP_M_INV) ? !mbit : !op_q[OPB_CLR];
  wire [7:0] bit_wr = (dm_rdata & ~bmask) | (wbit ? bmask : 8'h00);
  assign dm_wdata = (op_q == OP_TCLR) ? (dm_rdata & ~acc) :
                    (op_q == OP_TSET) ? (dm_rdata | acc) : bit_wr;
  assign dm_we = fin && ((nib == NIB_MBIT) || (op_q == OP_M_INV) ||
                         (op_q == OP_C_STORE) || (op_q == OP_TCLR) || (op_q == OP_TSET));

  // ----------------------------------------
  // flag and accumulator results
  // ----------------------------------------
  // only the flags named by an opcode move; the rest hold
  always_comb
  begin
    next_psw = psw;
    next_acc = acc;
    case (op_q)
      OP_C_AND: next_psw.c = psw.c & mbe;
      OP_XOR1: next_psw.c = psw.c ^ mbe;
      OP_C_OR: next_psw.c = psw.c | mbe;
      OP_C_LOAD: next_psw.c = mbe;
      OP_BIT_DP, OP_BIT_ABS:
      begin
        next_psw.z = ((acc & dm_rdata) == 8'h00);
        next_psw.n = dm_rdata[7];
        next_psw.v = dm_rdata[6];
      end
      OP_TCLR, OP_TSET:
      begin
        next_psw.n = diff[7];
        next_psw.z = (diff == 8'h00);
      end
      OP_ACLR: next_acc = acc & ~amask;
      OP_ASET: next_acc = acc | amask;
      OP_C_CLEAR: next_psw.c = 1'b0;
      OP_C_FORCE: next_psw.c = 1'b1;
      OP_G_CLEAR: next_psw.g = 1'b0;
      OP_G_FORCE: next_psw.g = 1'b1;
      OP_V_CLEAR: next_psw.v = 1'b0;
      default: next_psw = psw;
    endcase
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  // zero wait state, always okay; writes land in the data phase
  logic wr_pend;
  logic [7:0] wr_addr;
  wire addr_ok = hsel && htrans[1] && hready;
  wire [31:0] rd_word =
    (haddr[7:0] == REG_CTRL) ? {31'h0, run} :
    (haddr[7:0] == REG_STATUS) ? {29'h0, run, illegal, active} :
    (haddr[7:0] == REG_PC) ? {16'h0000, pc} :
    (haddr[7:0] == REG_ACC) ? {24'h000000, acc} :
    (haddr[7:0] == REG_PSW) ? {24'h000000, psw} : 32'h0;
  wire wr_ctrl = wr_pend && (wr_addr == REG_CTRL);
  // core state is only written by software while the core stands idle
  wire wr_pc = wr_pend && (wr_addr == REG_PC) && idle;
  wire wr_acc = wr_pend && (wr_addr == REG_ACC) && idle;
  wire wr_psw = wr_pend && (wr_addr == REG_PSW) && idle;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture and registered read data
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
      if (addr_ok && !hwrite)
        hrdata <= rd_word;
    end
  end

  // run control and the sticky illegal flag; the set wins over the clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      run <= 1'b0;
      illegal <= 1'b0;
    end
    else
    begin
      if (ill_hit)
        run <= 1'b0;
      else if (wr_ctrl)
        run <= hwdata[CTRL_RUN];
      if (ill_hit)
        illegal <= 1'b1;
      else if (wr_ctrl && hwdata[CTRL_CLR_ILL])
        illegal <= 1'b0;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // cycle 0 takes the opcode, the next cycles take operand bytes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cyc <= 4'h0;
      op_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
    end
    else
    begin
      if (fin || ill_hit)
        cyc <= 4'h0;
      else if (active || run)
        cyc <= cyc + 4'h1;
      if (!active && run)
        op_q <= pm_rdata;
      if (cyc == 4'h1)
        b1_q <= pm_rdata;
      if (cyc == 4'h2)
        b2_q <= pm_rdata;
    end
  end

  // architectural registers update on the last cycle of an instruction
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pc <= PC_RST;
      acc <= 8'h00;
      psw <= '0;
    end
    else if (fin)
    begin
      pc <= next_pc;
      acc <= next_acc;
      psw <= next_psw;
    end
    else
    begin
      if (wr_pc)
        pc <= hwdata[15:0];
      if (wr_acc)
        acc <= hwdata[7:0];
      if (wr_psw)
        psw <= hwdata[7:0];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire fc = psw.c;

  carry_and_a: assert property ((fin && op_q == OP_C_AND) |=> fc == ($past(fc) & $past(mbe)))
    else $error("carry and result wrong");
  xor_timing_a: assert property ((cyc == 4'h1 && op_q == OP_XOR1) |-> !fin ##3 fin)
    else $error("carry xor cycle count wrong");
  carry_or_a: assert property ((fin && op_q == OP_C_OR) |=> fc == ($past(fc) | $past(mbe)))
    else $error("carry or result wrong");
  carry_load_a: assert property ((fin && op_q == OP_C_LOAD) |=> fc == $past(mbe))
    else $error("carry load result wrong");
  bit_test_a: assert property ((fin && op_q == OP_BIT_ABS) |=> psw.n == $past(dm_rdata[7]))
    else $error("bit test negative wrong");
  mem_bit_a: assert property ((fin && nib == NIB_MBIT) |-> dm_we && dm_wdata[bsel] == !op_q[OPB_CLR])
    else $error("direct page bit write wrong");
  acc_bit_a: assert property ((fin && op_q == OP_ASET) |=> acc[$past(abit)] && psw == $past(psw))
    else $error("accumulator bit set wrong");
  carry_force_a: assert property ((fin && op_q == OP_C_FORCE) |=> fc)
    else $error("carry force failed");
  carry_store_a: assert property ((fin && op_q == OP_C_STORE) |-> dm_we && dm_wdata[bsel] == fc)
    else $error("carry store bit wrong");
  // taken carry branch lands at the end of the two bytes plus the signed offset
  carry_branch_a: assert property ((fin && op_q == OP_BR_C1 && fc) |=>
    pc == $past(pc) + {14'h0000, LEN2} + {{8{$past(b1_q[7])}}, $past(b1_q)})
    else $error("carry branch target wrong");
endmodule
`default_nettype wire

//--- testbench/bbx_mem_model.sv
// program and data memory model standing on the far side of the executor
`timescale 1ns/1ps
`default_nettype none
module bbx_mem_model
(
  // clock
  input wire logic clk_sys,
  // program side
  input wire logic [15:0] pm_addr,
  output logic [7:0] pm_rdata,
  // data side
  input wire logic [15:0] dm_addr,
  output logic [7:0] dm_rdata,
  input wire logic dm_we,
  input wire logic [7:0] dm_wdata
);
  // byte arrays, loaded by the bench while the core is halted
  logic [7:0] pmem [0:65535];
  logic [7:0] dmem [0:65535];
  // reads are combinational, so the core sees a byte in its own cycle
  assign pm_rdata = pmem[pm_addr];
  assign dm_rdata = dmem[dm_addr];
  // write lands at the edge that ends the strobe cycle
  always @(posedge clk_sys)
  begin
    if (dm_we === 1'b1)
      dmem[dm_addr] <= dm_wdata;
  end
endmodule
`default_nettype wire

//--- testbench/bbx_exec_tb.sv
// self-checking bench of the bit and branch executor
`timescale 1ns/1ps
`default_nettype none
module bbx_exec_tb;
  import bbx_pkg::*;
  // row: op b1 b2, end pc, acc psw mem, expected acc psw mem, cycles, timing mode
  typedef logic [95:0] bbx_row_t;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  localparam int LIMIT = 20000; // tests take near 1100 cycles; room for slow polls
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic hready; // single slave, so its ready is the bus ready
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] pm_addr;
  logic [15:0] dm_addr;
  logic [7:0] pm_rdata;
  logic [7:0] dm_rdata;
  logic [7:0] dm_wdata;
  logic dm_we;
  int num_errors = 0;
  int num_checks = 0;
  logic [15:0] cyc = 16'h0; // cycle counter, also the timeout clock
  logic [15:0] t0; // counter value in the first cycle of a run
  logic [15:0] we_at; // counter at the first write strobe
  logic [15:0] hit_at; // counter at the first fetch of the watched address
  logic [15:0] watch;
  logic [31:0] rd;
  // mode 1 times the write strobe, mode 2 the next fetch; memory byte sits at 0x40, bit 3 except for opcodes e1 (bit 7) and 11 (bit 0)
  bbx_row_t rows [40] = '{
    96'h8b4060_0203_00c308_00c308_00,
    96'h8b4070_0203_00c308_00c208_00,
    96'hab4060_0203_000308_000208_00,
    96'hab4070_0203_008200_008300_00,
    96'h6b4060_0203_000008_000108_00,
    96'h6b4070_0203_000008_000008_00,
    96'hcb4060_0203_00f008_00f108_00,
    96'hcb4070_0203_00f108_00f008_00,
    96'h0c4000_0202_0f00c0_0fc2c0_00,
    96'h1c4000_0203_808140_804340_00,
    96'h714000_0202_0055ff_0055f7_41,
    96'he14000_0202_000000_000080_41,
    96'h114000_0202_000001_000000_41,
    96'h2b0500_0202_ff0000_df0000_00,
    96'h0b0700_0202_000000_800000_00,
    96'h200000_0201_00ff00_00fe00_00,
    96'ha00000_0201_000000_000100_00,
    96'h400000_0201_00ff00_00df00_00,
    96'hc00000_0201_000000_002000_00,
    96'h800000_0201_00ff00_00bf00_00,
    96'h4b4060_0203_000008_000000_51,
    96'heb4060_0203_000100_000108_61,
    96'heb4060_0203_0000ff_0000f7_61,
    96'h5c4000_0203_0f023c_0f8030_61,
    96'h5c4000_0203_3c803c_3c0200_61,
    96'h3c4000_0203_3c803c_3c023c_61,
    96'h3c4000_0203_010080_018081_61,
    96'h72f000_01f2_000000_000000_62,
    96'h734080_0183_000000_000000_72,
    96'h72f000_0202_080000_080000_00,
    96'h627f00_0281_080000_080000_62,
    96'h634000_0203_000000_000000_00,
    96'h50fa00_01fc_000000_000000_42,
    96'hd08000_0182_000100_000100_42,
    96'hd08000_0202_000000_000000_22,
    96'hf01000_0212_000200_000200_42,
    96'h701000_0202_000200_000200_22,
    96'h90f000_01f2_008000_008000_42,
    96'h100500_0207_000000_000000_42,
    96'h100500_0202_008000_008000_22
  };
  // ---------------------------------------------
  // design and memory partner
  // ---------------------------------------------
  bbx_exec DUT (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
    .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_wdata(dm_wdata));
  bbx_mem_model model (.clk_sys(clk_sys), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_wdata(dm_wdata));
  // 50 ns period
  always #25 clk_sys = ~clk_sys;
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // event recorder and hang guard; first events only, so later traffic cannot mask them
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 16'h1;
    if (we_at == 16'hffff && dm_we === 1'b1)
      we_at <= cyc;
    if (hit_at == 16'hffff && pm_addr === watch)
      hit_at <= cyc;
    if (cyc == LIMIT)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one single transfer; entered just after a rising edge, read data left in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // every mapped word and a few unmapped ones must read zero
  task automatic all_zero();
    for (int k = 0; k < 9; k++)
    begin
      ahb(1'b0, 8'(k * 4), 32'h0);
      chk("cleared word", rd, 32'h0);
    end
  endtask
  // load one instruction, an unknown opcode at its end pc, run until the core halts
  task automatic run_row(input bbx_row_t r);
    int i;
    ahb(1'b1, REG_CTRL, 32'h2);
    ahb(1'b1, REG_PC, 32'h200);
    ahb(1'b1, REG_ACC, {24'h0, r[55:48]});
    ahb(1'b1, REG_PSW, {24'h0, r[47:40]});
    model.pmem[16'h200] = r[95:88];
    model.pmem[16'h201] = r[87:80];
    model.pmem[16'h202] = r[79:72];
    model.pmem[r[71:56]] = 8'hff;
    model.dmem[16'h40] = r[39:32];
    watch = r[71:56];
    ahb(1'b1, REG_CTRL, 32'h1);
    @(negedge clk_sys);
    t0 = cyc;
    we_at = 16'hffff;
    hit_at = 16'hffff;
    @(posedge clk_sys);
    i = 0;
    do
    begin
      ahb(1'b0, REG_STATUS, 32'h0);
      i++;
    end
    while (rd[2] !== 1'b0 && i < 30);
    chk("status", rd, 32'h2);
    ahb(1'b0, REG_PC, 32'h0);
    chk("pc", rd, {16'h0, r[71:56]});
    ahb(1'b0, REG_ACC, 32'h0);
    chk("acc", rd, {24'h0, r[31:24]});
    ahb(1'b0, REG_PSW, 32'h0);
    chk("psw", rd, {24'h0, r[23:16]});
    chk("memory", {24'h0, model.dmem[16'h40]}, {24'h0, r[15:8]});
    // strobe in the last cycle, next fetch one cycle after it
    if (r[3:0] == 4'h1)
      chk("write cycle", {16'h0, we_at - t0}, {28'h0, r[7:4] - 4'h1});
    if (r[3:0] == 4'h2)
      chk("fetch cycle", {16'h0, hit_at - t0}, {28'h0, r[7:4]});
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    all_zero();
    foreach (rows[k])
      run_row(rows[k]);
    // back to back: carry set, then a branch that depends on it
    run_row(96'ha0d004_0207_000000_000100_00);
    // endless self-branch; register writes must be refused while it runs
    ahb(1'b1, REG_CTRL, 32'h2);
    ahb(1'b1, REG_PC, 32'h200);
    ahb(1'b1, REG_ACC, 32'h11);
    ahb(1'b1, REG_PSW, 32'h0);
    model.pmem[16'h200] = 8'h50;
    model.pmem[16'h201] = 8'hfe;
    ahb(1'b1, REG_CTRL, 32'h1);
    ahb(1'b1, REG_ACC, 32'h55);
    ahb(1'b0, REG_ACC, 32'h0);
    chk("acc while running", rd, 32'h11);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk("still running", {31'h0, rd[2]}, 32'h1);
    ahb(1'b1, 8'h18, 32'hffffffff);
    // reset in mid-run clears the core and the registers
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    all_zero();
    close_out();
  end
endmodule
`default_nettype wire
